// File: hw/ccd_cfg_debug_regs.sv
/*
 * Configuration, debug run counter, version, register files and privilege
 * gate of the processor core, reached by software over a plain register
 * port and by the core over operand, write-back and bus-request ports.
 * Assumes one clock and requesters on that same clock.
 */
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps
`include "ccd_defines.svh"

module ccd_cfg_debug_regs
  import ccd_pkg::*;
#(
  parameter logic [15:0] VERSION_NUM  = 16'h00a5, // Arbitrary value.
  parameter logic [15:0] REVISION_LVL = 16'h0011, // Arbitrary value.
  parameter bit          FP_PRESENT   = 1'b1
) (
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // Software register port.
  input  wire logic [`CCD_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  // Trap entry forces supervisor mode.
  input  wire logic                   trap_enter,
  // Privileged operation check.
  input  wire logic                   op_check_valid,
  input  wire logic                   op_is_privileged,
  output logic                        op_allowed,
  output logic                        op_refused,
  // Integer operands and write-back.
  input  ccd_operand_req_t            operand_req,
  output logic                        operand_valid,
  output logic      [31:0]            operand_a,
  output logic      [31:0]            operand_b,
  input  ccd_int_wb_t                 int_wb,
  // Floating-point operands and write-back.
  input  wire logic                   fp_rd_valid,
  input  wire logic [4:0]             fp_src,
  output logic      [63:0]            fp_operand,
  input  ccd_fp_wb_t                  fp_wb,
  // Condition flags.
  input  ccd_cr_wb_t                  cr_wb,
  output logic      [31:0]            condition_flags,
  // Bus attributes and cache operations.
  output logic                        fetch_coherence_attr,
  input  ccd_cache_req_t              cache_req,
  output ccd_cache_req_t              bus_addr_only,
  output logic                        cache_op_local,
  // Snoop port.
  input  wire logic                   snoop_valid,
  input  wire logic                   snoop_is_cache_op,
  output logic                        snoop_accept,
  // Run control.
  output logic                        core_run,
  output logic                        core_halt,
  output logic                        supervisor_mode
);

  logic [31:0]    impl_config_0_q;
  logic [31:0]    machine_state_reg_q;
  logic [31:0]    condition_flags_q;
  logic [32:0]    debug_run_counter_q;
  ccd_run_state_t run_state_q;
  logic [31:0]    integer_register_file [32];
  logic [31:0]    rdata_d;
  logic [31:0]    imm_ext;
  logic           supervisor;
  logic           wr_impl;
  logic           wr_count;
  logic           wr_ctrl;
  logic           wr_msr;
  logic           wr_cr;

  // Privilege bit set means user mode.
  assign supervisor = ~machine_state_reg_q[`CCD_BIT_PRIV_LEVEL];
  assign supervisor_mode = supervisor;

  // Supervisor registers ignore user-mode writes; flags stay user writable.
  assign wr_impl  = reg_wr && supervisor &&
                    (reg_addr == `CCD_OFF_IMPL_CFG0);
  assign wr_count = reg_wr && supervisor &&
                    (reg_addr == `CCD_OFF_RUN_COUNT);
  assign wr_ctrl  = reg_wr && supervisor &&
                    (reg_addr == `CCD_OFF_RUN_CTRL);
  assign wr_msr   = reg_wr && supervisor &&
                    (reg_addr == `CCD_OFF_MACH_STATE);
  assign wr_cr    = reg_wr && (reg_addr == `CCD_OFF_COND_FLAGS);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      impl_config_0_q <= `CCD_RST_IMPL_CFG0;
    end else if (wr_impl) begin
      impl_config_0_q <= reg_wdata;
    end
  end

  // Trap entry wins over a software write in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      machine_state_reg_q <= `CCD_RST_MACH_STATE;
    end else if (trap_enter) begin
      machine_state_reg_q[`CCD_BIT_PRIV_LEVEL] <= 1'b0;
    end else if (wr_msr) begin
      machine_state_reg_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      op_allowed <= 1'b0;
      op_refused <= 1'b0;
    end else begin
      op_allowed <= op_check_valid && (supervisor || !op_is_privileged);
      op_refused <= op_check_valid && !supervisor && op_is_privileged;
    end
  end

  // Upper 32 bits count down; the low bit changes only on run-control writes.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      debug_run_counter_q <= `CCD_RST_RUN_COUNT;
      run_state_q         <= CCD_RUN_IDLE;
    end else begin
      if (wr_count) begin
        debug_run_counter_q[32:1] <= reg_wdata;
      end else if (run_state_q == CCD_RUN_COUNTING &&
                   debug_run_counter_q[32:1] != 32'h0000_0000) begin
        debug_run_counter_q[32:1] <= debug_run_counter_q[32:1] - 32'h1;
      end
      if (wr_ctrl) begin
        debug_run_counter_q[`CCD_BIT_RUN_LSB] <=
          reg_wdata[`CCD_BIT_RUN_LSB];
      end
      unique case (run_state_q)
        CCD_RUN_IDLE, CCD_RUN_HALTED: begin
          if (wr_ctrl && reg_wdata[`CCD_BIT_RUN_GO]) begin
            run_state_q <= CCD_RUN_COUNTING;
          end
        end
        CCD_RUN_COUNTING: begin
          if (wr_ctrl && !reg_wdata[`CCD_BIT_RUN_GO]) begin
            run_state_q <= CCD_RUN_IDLE;
          end else if (!wr_count &&
                       debug_run_counter_q[32:1] <= 32'h0000_0001) begin
            run_state_q <= CCD_RUN_HALTED;
          end
        end
        default: begin
          run_state_q <= CCD_RUN_IDLE;
        end
      endcase
    end
  end

  assign core_run  = (run_state_q == CCD_RUN_COUNTING) ||
                     (run_state_q == CCD_RUN_IDLE);
  assign core_halt = (run_state_q == CCD_RUN_HALTED);

  // Whole-register writes from software lose to a field write from the core.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      condition_flags_q <= `CCD_RST_COND_FLAGS;
    end else begin
      if (wr_cr) begin
        condition_flags_q <= reg_wdata;
      end
      if (cr_wb.valid) begin
        condition_flags_q[{cr_wb.field, 2'b00} +: 4] <= cr_wb.value;
      end
    end
  end
  assign condition_flags = condition_flags_q;

  always_ff @(posedge clk_sys) begin
    if (int_wb.valid) begin
      integer_register_file[int_wb.dest] <= int_wb.value;
    end
  end

  assign imm_ext = {{16{operand_req.imm[15]}}, operand_req.imm};

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      operand_valid <= 1'b0;
      operand_a     <= 32'h0000_0000;
      operand_b     <= 32'h0000_0000;
    end else begin
      operand_valid <= operand_req.valid;
      if (operand_req.valid) begin
        operand_a <= integer_register_file[operand_req.src_a];
        operand_b <= operand_req.use_imm ? imm_ext :
                     integer_register_file[operand_req.src_b];
      end
    end
  end

  // Reduced variant has no floating-point storage and reads zero.
  generate
    if (FP_PRESENT) begin : g_fp
      logic [63:0] float_register_file [32];
      always_ff @(posedge clk_sys) begin
        if (fp_wb.valid) begin
          float_register_file[fp_wb.dest] <= fp_wb.value;
        end
      end
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          fp_operand <= 64'h0000_0000_0000_0000;
        end else if (fp_rd_valid) begin
          fp_operand <= float_register_file[fp_src];
        end
      end
    end else begin : g_no_fp
      always_ff @(posedge clk_sys) begin
        fp_operand <= 64'h0000_0000_0000_0000;
      end
    end
  endgenerate

  assign fetch_coherence_attr =
    impl_config_0_q[`CCD_BIT_FETCH_COH];

  // Cache-block operations leave as address-only bus requests when enabled.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bus_addr_only  <= '0;
      cache_op_local <= 1'b0;
    end else begin
      bus_addr_only.valid <= cache_req.valid &&
                             impl_config_0_q[`CCD_BIT_BCAST_EN];
      bus_addr_only.op    <= cache_req.op;
      bus_addr_only.addr  <= cache_req.addr;
      cache_op_local      <= cache_req.valid &&
                             !impl_config_0_q[`CCD_BIT_BCAST_EN];
    end
  end

  // Broadcast cache-block operations from other masters are never taken.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      snoop_accept <= 1'b0;
    end else begin
      snoop_accept <= snoop_valid && !snoop_is_cache_op;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (reg_addr)
      `CCD_OFF_IMPL_CFG0:  rdata_d = impl_config_0_q;
      `CCD_OFF_RUN_COUNT:  rdata_d = debug_run_counter_q[32:1];
      `CCD_OFF_RUN_CTRL: begin
        rdata_d[`CCD_BIT_RUN_LSB] = debug_run_counter_q[`CCD_BIT_RUN_LSB];
        rdata_d[`CCD_BIT_RUN_GO]  = (run_state_q == CCD_RUN_COUNTING);
      end
      `CCD_OFF_COND_FLAGS: rdata_d = condition_flags_q;
      `CCD_OFF_VERSION_ID: rdata_d = {VERSION_NUM, REVISION_LVL};
      `CCD_OFF_MACH_STATE: rdata_d = machine_state_reg_q;
      `CCD_OFF_RUN_STATUS: begin
        rdata_d[`CCD_BIT_ST_HALTED]   = (run_state_q == CCD_RUN_HALTED);
        rdata_d[`CCD_BIT_ST_COUNTING] = (run_state_q == CCD_RUN_COUNTING);
      end
      default:             rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : 32'h0000_0000;
    end
  end

endmodule : ccd_cfg_debug_regs

// File: hw/ccd_defines.svh
/*
 * Register offsets, field positions, reset values and sizes of the
 * processor configuration and debug register bank.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH

`define CCD_ADDR_W          8
`define CCD_OFF_IMPL_CFG0   8'h00
`define CCD_OFF_RUN_COUNT   8'h04
`define CCD_OFF_RUN_CTRL    8'h08
`define CCD_OFF_COND_FLAGS  8'h0c
`define CCD_OFF_VERSION_ID  8'h10
`define CCD_OFF_MACH_STATE  8'h14
`define CCD_OFF_RUN_STATUS  8'h18

`define CCD_BIT_FETCH_COH   24
`define CCD_BIT_BCAST_EN    28
`define CCD_BIT_PRIV_LEVEL  14
`define CCD_BIT_RUN_LSB     0
`define CCD_BIT_RUN_GO      1
`define CCD_BIT_ST_HALTED   0
`define CCD_BIT_ST_COUNTING 1

`define CCD_RST_IMPL_CFG0   32'h0000_0000
`define CCD_RST_MACH_STATE  32'h0000_0000
`define CCD_RST_COND_FLAGS  32'h0000_0000
`define CCD_RST_RUN_COUNT   33'h0_0000_0000

`endif

// File: hw/ccd_pkg.sv
/*
 * Types shared by the configuration and debug register bank.
 * Assumes the defines header sits on the include path.
 */
package ccd_pkg;

  typedef enum logic [1:0] {
    CCD_COP_FLUSH = 2'b00,
    CCD_COP_INVAL = 2'b01,
    CCD_COP_STORE = 2'b10
  } ccd_cache_op_t;

  typedef enum logic [1:0] {
    CCD_RUN_IDLE     = 2'b00,
    CCD_RUN_COUNTING = 2'b01,
    CCD_RUN_HALTED   = 2'b10
  } ccd_run_state_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  src_a;
    logic [4:0]  src_b;
    logic        use_imm;
    logic [15:0] imm;
  } ccd_operand_req_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [31:0] value;
  } ccd_int_wb_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [63:0] value;
  } ccd_fp_wb_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] field;
    logic [3:0] value;
  } ccd_cr_wb_t;

  typedef struct packed {
    logic          valid;
    ccd_cache_op_t op;
    logic [31:0]   addr;
  } ccd_cache_req_t;

endpackage : ccd_pkg

// File: sim/ccd_cfg_debug_regs_assertions.sv
/* Concurrent checks on the register bank ports.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/100ps

module ccd_cfg_debug_regs_chk
  import ccd_pkg::*;
#(
  parameter logic [15:0] VERSION_NUM  = 16'h00a5,
  parameter logic [15:0] REVISION_LVL = 16'h0011
) (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // Register port.
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Privilege.
  input wire logic        supervisor_mode,
  input wire logic        op_check_valid,
  input wire logic        op_is_privileged,
  input wire logic        op_allowed,
  input wire logic        op_refused,
  // Bus side.
  input wire logic        fetch_coherence_attr,
  input ccd_cache_req_t   cache_req,
  input ccd_cache_req_t   bus_addr_only,
  input wire logic        cache_op_local,
  input wire logic        snoop_valid,
  input wire logic        snoop_is_cache_op,
  input wire logic        snoop_accept,
  // Run control.
  input wire logic        core_halt
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_attr;
    reg_wr && reg_addr == 8'h00 && supervisor_mode
    |=> fetch_coherence_attr == $past(reg_wdata[24]);
  endproperty
  a_attr: assert property (p_attr)
    else $error("fetch attribute wrong");

  property p_cop;
    cache_req.valid |=> bus_addr_only.valid != cache_op_local
      && bus_addr_only.addr == $past(cache_req.addr);
  endproperty
  a_cop: assert property (p_cop)
    else $error("cache operation routed wrong");

  property p_snp;
    snoop_valid |=> snoop_accept == !$past(snoop_is_cache_op);
  endproperty
  a_snp: assert property (p_snp)
    else $error("snoop answer wrong");

  property p_ref;
    op_check_valid && op_is_privileged && !supervisor_mode
    |=> op_refused && !op_allowed;
  endproperty
  a_ref: assert property (p_ref)
    else $error("privileged operation not refused");

  property p_alw;
    op_check_valid && (supervisor_mode || !op_is_privileged)
    |=> op_allowed && !op_refused;
  endproperty
  a_alw: assert property (p_alw)
    else $error("operation not allowed");

  property p_hold;
    core_halt && !(reg_wr && reg_addr == 8'h08) |=> core_halt;
  endproperty
  a_hold: assert property (p_hold)
    else $error("halt dropped");

  property p_go;
    core_halt && reg_wr && reg_addr == 8'h08 && reg_wdata[1]
      && supervisor_mode |=> !core_halt;
  endproperty
  a_go: assert property (p_go)
    else $error("restart ignored");

  property p_ver;
    reg_rd && reg_addr == 8'h10
    |=> reg_rdata == {VERSION_NUM, REVISION_LVL};
  endproperty
  a_ver: assert property (p_ver)
    else $error("version read wrong");
endmodule : ccd_cfg_debug_regs_chk

bind ccd_cfg_debug_regs ccd_cfg_debug_regs_chk #(
  .VERSION_NUM(VERSION_NUM), .REVISION_LVL(REVISION_LVL)
) ccd_cfg_debug_regs_chk_inst (
  .clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .supervisor_mode, .op_check_valid, .op_is_privileged,
  .op_allowed, .op_refused, .fetch_coherence_attr, .cache_req,
  .bus_addr_only, .cache_op_local, .snoop_valid, .snoop_is_cache_op,
  .snoop_accept, .core_halt
);

// File: sim/ccd_cfg_debug_regs_tb_top.sv
/* Self-checking bench for the register bank.
   Assumes the package and the checker are compiled first. */
`timescale 1ns/100ps

module ccd_cfg_debug_regs_tb_top
  import ccd_pkg::*;
;
  localparam logic [15:0] VN = 16'h005a; // Arbitrary value.
  localparam logic [15:0] RV = 16'h0003; // Arbitrary value.
  logic             clk_sys, reset_n, reg_wr, reg_rd, trap_enter;
  logic             op_check_valid, op_is_privileged, op_allowed;
  logic             op_refused, operand_valid, fp_rd_valid, core_run;
  logic             snoop_valid, snoop_is_cache_op, snoop_accept;
  logic             fetch_coherence_attr, cache_op_local, core_halt;
  logic             supervisor_mode;
  logic [4:0]       fp_src;
  logic [7:0]       reg_addr;
  logic [31:0]      reg_wdata, reg_rdata, operand_a, operand_b, v, cr;
  logic [31:0]      condition_flags;
  logic [63:0]      fp_operand;
  logic [31:0]      im [32];
  logic [63:0]      fm [32];
  ccd_operand_req_t operand_req;
  ccd_int_wb_t      int_wb;
  ccd_fp_wb_t       fp_wb;
  ccd_cr_wb_t       cr_wb;
  ccd_cache_req_t   cache_req, bus_addr_only;
  int               checked, mismatches, n, c;

  ccd_cfg_debug_regs #(.VERSION_NUM(VN), .REVISION_LVL(RV))
  ccd_cfg_debug_regs_inst (
    .clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .trap_enter, .op_check_valid, .op_is_privileged,
    .op_allowed, .op_refused, .operand_req, .operand_valid, .operand_a,
    .operand_b, .int_wb, .fp_rd_valid, .fp_src, .fp_operand, .fp_wb,
    .cr_wb, .condition_flags, .fetch_coherence_attr, .cache_req,
    .bus_addr_only, .cache_op_local, .snoop_valid, .snoop_is_cache_op,
    .snoop_accept, .core_run, .core_halt, .supervisor_mode
  );

  task chk(input logic [63:0] e, input logic [63:0] g, input string s);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e, input string s);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(e, reg_rdata, s);
  endtask : rd

  task op(input logic p, input logic e);
    @(posedge clk_sys);
    op_check_valid <= 1'b1;
    op_is_privileged <= p;
    @(posedge clk_sys);
    op_check_valid <= 1'b0;
    #1;
    chk({e, !e}, {op_allowed, op_refused}, "op");
  endtask : op

  task results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    #400000;
    mismatches++;
    results;
  end

  initial begin
    {reset_n, reg_wr, reg_rd, trap_enter, op_check_valid, fp_rd_valid,
     op_is_privileged, snoop_valid, snoop_is_cache_op, fp_src, reg_addr,
     reg_wdata, operand_req, int_wb, fp_wb, cr_wb, cache_req} = '0;
    cr = '0;
    v = $urandom(82897);
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(8'h10, {VN, RV}, "version");
    wr(8'h10, ~{VN, RV});
    rd(8'h10, {VN, RV}, "version ro");
    rd(8'h1c, 32'h0, "unmapped");
    v = $urandom;
    wr(8'h00, v);
    chk(v[24], fetch_coherence_attr, "attr");
    $display("test registers done");
    for (int b = 0; b < 2; b++) begin
      wr(8'h00, {3'h0, b[0], 28'h0});
      for (int o = 0; o < 3; o++) begin
        v = $urandom;
        @(posedge clk_sys);
        cache_req <= '{1'b1, ccd_cache_op_t'(o), v};
        snoop_valid <= 1'b1;
        snoop_is_cache_op <= o[0];
        @(posedge clk_sys);
        cache_req.valid <= 1'b0;
        snoop_valid <= 1'b0;
        #1;
        chk({b[0], v}, {bus_addr_only.valid, bus_addr_only.addr}, "bc");
        chk(o, bus_addr_only.op, "bc op");
        chk(!b, cache_op_local, "local");
        chk(!o[0], snoop_accept, "snoop");
      end
    end
    $display("test cache ops done");
    for (int k = 0; k < 4; k++) begin
      n = (k < 3) ? k : 2 + $urandom % 9;
      wr(8'h04, n);
      wr(8'h08, 32'h2);
      c = 0;
      while (!core_halt && c < 50) begin
        @(posedge clk_sys);
        #1;
        c++;
      end
      chk((n < 2) ? 1 : n, c, "cycles");
      rd(8'h18, 32'h1, "status");
      chk(0, core_run, "run stopped");
    end
    wr(8'h08, 32'h1);
    rd(8'h08, 32'h1, "lsb");
    $display("test run counter done");
    wr(8'h00, 32'h0100_0000);
    chk(1, fetch_coherence_attr, "attr set");
    wr(8'h14, 32'h4000);
    chk(0, supervisor_mode, "user");
    op(1'b1, 1'b0);
    op(1'b0, 1'b1);
    wr(8'h00, 32'h0000_0000);
    chk(1, fetch_coherence_attr, "user write");
    @(posedge clk_sys);
    trap_enter <= 1'b1;
    @(posedge clk_sys);
    trap_enter <= 1'b0;
    #1;
    chk(1, supervisor_mode, "trap");
    op(1'b1, 1'b1);
    $display("test privilege done");
    for (int i = 0; i < 32; i++) begin
      im[i] = $urandom;
      fm[i] = {$urandom, $urandom};
      v = $urandom;
      cr[4 * (i % 8) +: 4] = v[3:0];
      @(posedge clk_sys);
      int_wb <= '{1'b1, 5'(i), im[i]};
      fp_wb <= '{1'b1, 5'(i), fm[i]};
      cr_wb <= '{1'b1, 3'(i), v[3:0]};
      @(posedge clk_sys);
      int_wb.valid <= 1'b0;
      fp_wb.valid <= 1'b0;
      cr_wb.valid <= 1'b0;
      #1;
      chk(cr, condition_flags, "flags");
    end
    for (int i = 0; i < 32; i++) begin
      v = $urandom;
      @(posedge clk_sys);
      operand_req <= '{1'b1, 5'(i), v[4:0], v[5], v[31:16]};
      fp_rd_valid <= 1'b1;
      fp_src <= 5'(31 - i);
      @(posedge clk_sys);
      operand_req.valid <= 1'b0;
      fp_rd_valid <= 1'b0;
      #1;
      chk({operand_valid, im[i]}, {1'b1, operand_a}, "opa");
      chk(v[5] ? {{16{v[31]}}, v[31:16]} : im[v[4:0]], operand_b, "opb");
      chk(fm[31 - i], fp_operand, "fp");
    end
    rd(8'h0c, cr, "flags read");
    $display("test register files done");
    results;
  end
endmodule : ccd_cfg_debug_regs_tb_top
